// ==== proc_timing_pkg.sv ====
package proc_timing_pkg;

    // ------------------------------------------------------------
    // Timing base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int MAJOR_CYCLE_NS = 1000;
    // A major cycle is a least time, so the count rounds up.
    localparam int MAJOR_CLKS = (MAJOR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 13;

    // ------------------------------------------------------------
    // Execution times in major cycles
    // ------------------------------------------------------------
    localparam logic [4:0] CYC_ONE = 5'h01;
    localparam logic [4:0] CYC_TWO = 5'h02;
    localparam logic [4:0] CYC_THREE = 5'h03;
    localparam logic [4:0] CYC_FOUR = 5'h04;
    localparam logic [4:0] CYC_EXTRA_REF = 5'h01;
    localparam logic [4:0] CYC_CM_SINGLE = 5'h06;
    localparam logic [4:0] CYC_CM_SETUP = 5'h05;
    localparam logic [4:0] CYC_CM_PER_WORD = 5'h05;
    localparam logic [4:0] CYC_CH_SETUP = 5'h04;
    localparam logic [4:0] CYC_EXCHANGE = 5'h14;

    // ------------------------------------------------------------
    // Opcode groups (upper three bits of the six-bit code)
    // ------------------------------------------------------------
    localparam logic [2:0] GRP_JUMP = 3'h0;
    localparam logic [2:0] GRP_NO_ADDR = 3'h1;
    localparam logic [2:0] GRP_LONG_IMM = 3'h2;
    localparam logic [2:0] GRP_DIRECT = 3'h3;
    localparam logic [2:0] GRP_INDIRECT = 3'h4;
    localparam logic [2:0] GRP_INDEXED = 3'h5;
    localparam logic [2:0] GRP_CENTRAL = 3'h6;
    localparam logic [2:0] GRP_CHANNEL = 3'h7;
    localparam logic [5:0] OP_EXCHANGE = 6'h16;
    localparam logic [5:0] OP_LONG_JUMP = 6'h01;
    localparam logic [5:0] OP_RETURN_JUMP = 6'h02;
    localparam logic [5:0] OP_CM_READ_BLOCK = 6'h31;
    localparam logic [5:0] OP_CM_WRITE_BLOCK = 6'h33;
    localparam logic [5:0] OP_CH_IN_BLOCK = 6'h39;
    localparam logic [5:0] OP_CH_OUT_BLOCK = 6'h3B;
    localparam logic [2:0] SUB_FIRST_REPLACE = 3'h5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {KIND_PLAIN, KIND_CM_ONE, KIND_CM_BLOCK, KIND_CH_BLOCK, KIND_EXCHANGE} kind_t;
    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_CH_WORDS} phase_t;

    typedef struct packed {
        logic [5:0] opcode;
        logic index_ref;
        logic [11:0] word_count;
    } instr_t;

    typedef struct packed {
        kind_t kind;
        logic [4:0] cycles;
        logic mem_ref;
    } class_t;

    typedef struct packed {
        phase_t phase;
        kind_t kind;
        logic [DIV_W-1:0] div;
        logic [15:0] remaining;
        logic [11:0] words;
        logic [15:0] elapsed;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic issue_ready;
        logic done;
        logic cm_busy;
        logic cm_stalled;
        logic chan_strobe;
        logic xj_pending;
    } state_t;

endpackage

// ==== peripheral_proc_timing.sv ====
`timescale 1ns/1ns
`default_nettype none

module peripheral_proc_timing
    import proc_timing_pkg::*;
#(
    parameter int MAJOR_CLKS_P = MAJOR_CLKS
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic issue_valid,
    input wire instr_t issue,
    input wire logic cp_mem_req,
    input wire logic xj_complete,
    input wire logic chan_word_ack,
    output logic issue_ready,
    output logic done,
    output logic [15:0] elapsed,
    output logic cm_busy,
    output logic cm_stalled,
    output logic chan_strobe,
    output logic xj_pending
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The major-cycle divider is DIV_W bits wide and must count at least once.
    if (MAJOR_CLKS_P < 1 || MAJOR_CLKS_P > 4096) begin : g_bad_major
        $error("MAJOR_CLKS_P must lie between 1 and 4096");
    end

    // Last divider count of a major cycle; the tick fires on it.
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MAJOR_CLKS_P - 1);

    // ------------------------------------------------------------
    // Instruction classification
    // ------------------------------------------------------------
    // Maps an opcode to its kind, its base length in major cycles and whether
    // it touches memory beyond the instruction word itself.
    function automatic class_t classify(input instr_t ins);
        class_t c;
        logic replace;
        logic [4:0] idx;
        c.kind = KIND_PLAIN;
        c.cycles = CYC_ONE;
        c.mem_ref = 1'b0;
        replace = (ins.opcode[2:0] >= SUB_FIRST_REPLACE);
        idx = ins.index_ref ? CYC_EXTRA_REF : 5'h00;
        case (ins.opcode[5:3])
            GRP_JUMP: begin
                // Short-offset jumps and pass finish in one cycle.
                c.cycles = CYC_ONE;
                if (ins.opcode == OP_LONG_JUMP) begin
                    c.cycles = CYC_TWO + idx;
                    c.mem_ref = 1'b1;
                end else if (ins.opcode == OP_RETURN_JUMP) begin
                    c.cycles = CYC_THREE + idx;
                    c.mem_ref = 1'b1;
                end
            end
            GRP_NO_ADDR: begin
                // The operand sits in the instruction word itself.
                c.cycles = CYC_ONE;
            end
            GRP_LONG_IMM: begin
                if (ins.opcode[2:0] < 3'h4) begin
                    // One extra cycle fetches the wide operand field.
                    c.cycles = CYC_ONE + CYC_EXTRA_REF;
                    c.mem_ref = 1'b1;
                end else if (ins.opcode == OP_EXCHANGE) begin
                    c.kind = KIND_EXCHANGE;
                    c.cycles = CYC_EXCHANGE;
                end else begin
                    c.cycles = CYC_ONE;
                end
            end
            GRP_DIRECT: begin
                // Replace forms read, modify and write back, one cycle more.
                c.cycles = replace ? CYC_THREE : CYC_TWO;
                c.mem_ref = 1'b1;
            end
            GRP_INDIRECT: begin
                // The address word itself costs one more reference.
                c.cycles = (replace ? CYC_THREE : CYC_TWO) + CYC_EXTRA_REF;
                c.mem_ref = 1'b1;
            end
            GRP_INDEXED: begin
                // The m field plus an optional index reference.
                c.cycles = (replace ? CYC_THREE : CYC_TWO) + CYC_EXTRA_REF + idx;
                c.mem_ref = 1'b1;
            end
            GRP_CENTRAL: begin
                // Single words, counted blocks and the channel-state jumps.
                c.mem_ref = 1'b1;
                if (ins.opcode == OP_CM_READ_BLOCK || ins.opcode == OP_CM_WRITE_BLOCK) begin
                    c.kind = KIND_CM_BLOCK;
                    c.cycles = CYC_CM_SETUP;
                end else if (ins.opcode[2]) begin
                    c.cycles = CYC_TWO;
                end else begin
                    c.kind = KIND_CM_ONE;
                    c.cycles = CYC_CM_SINGLE;
                end
            end
            default: begin
                // Counted channel blocks pace on the equipment; the rest are fixed.
                c.mem_ref = 1'b1;
                if (ins.opcode == OP_CH_IN_BLOCK || ins.opcode == OP_CH_OUT_BLOCK) begin
                    c.kind = KIND_CH_BLOCK;
                    c.cycles = CYC_CH_SETUP;
                end else begin
                    c.cycles = CYC_TWO;
                end
            end
        endcase
        return c;
    endfunction

    // Central block length: setup plus a fixed count per word.
    function automatic logic [15:0] cm_block_len(input logic [11:0] wc);
        logic [15:0] per;
        per = 16'(CYC_CM_PER_WORD) * {4'h0, wc};
        return 16'(CYC_CM_SETUP) + per;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t s;
    state_t next_s;
    class_t cls;
    logic tick;
    logic accept;
    logic blocked;
    logic conflict;
    logic xj_done_seen;
    logic word_ready;

    // Classification, issue gating and the major-cycle tick.
    always_comb begin
        cls = classify(issue);
        tick = (s.div == DIV_LAST);
        // The second synchroniser stage is the only one read by logic.
        conflict = s.sync2[0];
        xj_done_seen = s.sync2[1];
        word_ready = s.sync2[2];
        // A pending exchange holds off any memory-touching instruction and a
        // second exchange, so the request simply waits at the issue port.
        blocked = s.xj_pending && (cls.mem_ref || cls.kind == KIND_EXCHANGE);
        accept = issue_valid && s.issue_ready && !blocked;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // One step of the timing machine; all state lives in one struct.
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.chan_strobe = 1'b0;
        next_s.cm_stalled = 1'b0;
        next_s.sync1 = {chan_word_ack, xj_complete, cp_mem_req};
        next_s.sync2 = s.sync1;
        next_s.div = tick ? '0 : s.div + DIV_W'(1);

        case (s.phase)
            PH_IDLE: begin
                if (accept) begin
                    // Restart the divider so the first major cycle is whole.
                    next_s.div = '0;
                    next_s.phase = PH_RUN;
                    next_s.kind = cls.kind;
                    next_s.issue_ready = 1'b0;
                    next_s.elapsed = 16'h0000;
                    next_s.words = issue.word_count;
                    next_s.remaining = {11'h000, cls.cycles};
                    // A central block costs its setup plus a fixed time per word.
                    if (cls.kind == KIND_CM_BLOCK) begin
                        next_s.remaining = cm_block_len(issue.word_count);
                    end
                    next_s.cm_busy = (cls.kind == KIND_CM_ONE || cls.kind == KIND_CM_BLOCK);
                end
            end
            PH_RUN: begin
                if (tick) begin
                    // Saturate so a very long stall cannot wrap the count.
                    if (s.elapsed != 16'hFFFF) begin
                        next_s.elapsed = s.elapsed + 16'h0001;
                    end
                    // A central memory major cycle with a processor request
                    // outstanding is spent waiting; elapsed counts it but remaining does not drop.
                    if (s.cm_busy && conflict) begin
                        next_s.cm_stalled = 1'b1;
                    end else if (s.remaining <= 16'h0001) begin
                        if (s.kind == KIND_CH_BLOCK && s.words != 12'h000) begin
                            next_s.phase = PH_CH_WORDS;
                        end else begin
                            next_s.phase = PH_IDLE;
                            next_s.done = 1'b1;
                            next_s.issue_ready = 1'b1;
                            next_s.cm_busy = 1'b0;
                        end
                    end else begin
                        next_s.remaining = s.remaining - 16'h0001;
                    end
                end
            end
            PH_CH_WORDS: begin
                // At most one word per major cycle, and only when the
                // equipment says it is ready; slow devices stretch the time.
                // The ready level is seen two clocks late through the synchroniser,
                // so equipment must drop it at least two clocks before the next tick to pause.
                if (tick) begin
                    if (s.elapsed != 16'hFFFF) begin
                        next_s.elapsed = s.elapsed + 16'h0001;
                    end
                    if (word_ready) begin
                        next_s.chan_strobe = 1'b1;
                        next_s.words = s.words - 12'h001;
                        if (s.words == 12'h001) begin
                            next_s.phase = PH_IDLE;
                            next_s.done = 1'b1;
                            next_s.issue_ready = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_s.phase = PH_IDLE;
                next_s.issue_ready = 1'b1;
            end
        endcase

        // The exchange flag is set on issue and cleared by the processor's
        // completion; a set in the same cycle wins.
        // A second exchange is never taken while the first is still pending.
        if (accept && cls.kind == KIND_EXCHANGE) begin
            next_s.xj_pending = 1'b1;
        end else if (xj_done_seen) begin
            next_s.xj_pending = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    // Synchronous reset puts every control bit at a defined value.
    // The synchroniser stages clear too, so no stale request outlives reset.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s.phase <= PH_IDLE;
            s.kind <= KIND_PLAIN;
            s.div <= '0;
            s.remaining <= 16'h0000;
            s.words <= 12'h000;
            s.elapsed <= 16'h0000;
            s.sync1 <= 3'h0;
            s.sync2 <= 3'h0;
            s.issue_ready <= 1'b1;
            s.done <= 1'b0;
            s.cm_busy <= 1'b0;
            s.cm_stalled <= 1'b0;
            s.chan_strobe <= 1'b0;
            s.xj_pending <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a field of the registered state.
    assign issue_ready = s.issue_ready;
    assign done = s.done;
    assign elapsed = s.elapsed;
    assign cm_busy = s.cm_busy;
    assign cm_stalled = s.cm_stalled;
    assign chan_strobe = s.chan_strobe;
    assign xj_pending = s.xj_pending;

endmodule

`default_nettype wire

// ==== proc_timing_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Timing checker
// ----------------------------------------
module proc_timing_checker #(
    parameter int MAJOR_CLKS_P = 2
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic issue_valid,
    input wire logic cp_mem_req,
    input wire logic xj_complete,
    input wire logic chan_word_ack,
    input wire logic issue_ready,
    input wire logic done,
    input wire logic [15:0] elapsed,
    input wire logic cm_busy,
    input wire logic cm_stalled,
    input wire logic chan_strobe,
    input wire logic xj_pending
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [15:0] gap;
    logic [15:0] busy_clks;
    logic [2:0] req_age;
    logic [2:0] ack_age;
    // Ages saturate, so the async inputs are judged through their sync delay.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gap <= 16'hFFFF;
            busy_clks <= 16'h0000;
            req_age <= 3'h7;
            ack_age <= 3'h7;
        end else begin
            gap <= chan_strobe ? 16'h0001 : (gap == 16'hFFFF ? gap : gap + 16'h0001);
            busy_clks <= cm_busy ? busy_clks + 16'h0001 : 16'h0000;
            req_age <= cp_mem_req ? 3'h0 : (req_age == 3'h7 ? req_age : req_age + 3'h1);
            ack_age <= chan_word_ack ? 3'h0 : (ack_age == 3'h7 ? ack_age : ack_age + 3'h1);
        end
    end
    strobe_space_a: assert property (chan_strobe |-> gap >= MAJOR_CLKS_P)
        else $error("channel words closer than one major cycle");
    strobe_cause_a: assert property (chan_strobe |-> ack_age <= 3'h2)
        else $error("channel word moved without equipment ready");
    stall_cause_a: assert property (cm_stalled |-> req_age <= 3'h2)
        else $error("stall without processor request");
    stall_scope_a: assert property (cm_stalled |-> cm_busy)
        else $error("stall outside central memory work");
    xj_guard_a: assert property ($rose(cm_busy) |-> !$past(xj_pending))
        else $error("memory work started during exchange");
    xj_clear_a: assert property (xj_pending && xj_complete |-> ##[1:4] !xj_pending)
        else $error("exchange pending not cleared");
    cm_time_a: assert property ($fell(cm_busy) |-> busy_clks >= 5 * MAJOR_CLKS_P)
        else $error("central memory work too short");
    take_cause_a: assert property ($fell(issue_ready) |-> $past(issue_valid))
        else $error("instruction taken without offer");
    done_ready_a: assert property (done |-> issue_ready && elapsed != 16'h0000)
        else $error("completion without ready or time");
endmodule
`default_nettype wire

// ==== proc_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Central processor and channel equipment
// ----------------------------------------
module proc_far_side (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cm_busy,
    input wire logic chan_strobe,
    input wire logic xj_pending,
    input wire logic [31:0] conflict_clks,
    input wire logic [31:0] ack_gap,
    input wire logic [31:0] xj_delay,
    output logic cp_mem_req,
    output logic xj_complete,
    output logic chan_word_ack
);
    logic busy_q;
    int cnt_c;
    int cnt_a;
    int cnt_x;
    // Level handshakes; completion is held until the pending flag drops.
    always @(posedge clk_sys) begin
        if (srst) begin
            {busy_q, cp_mem_req, xj_complete, chan_word_ack} <= 4'h0;
            {cnt_c, cnt_a, cnt_x} <= '0;
        end else begin
            busy_q <= cm_busy;
            cnt_c <= (cm_busy && !busy_q) ? conflict_clks : (cnt_c > 0 ? cnt_c - 1 : 0);
            cp_mem_req <= cnt_c > 0;
            if (chan_strobe && ack_gap > 0) begin
                chan_word_ack <= 1'b0;
                cnt_a <= ack_gap;
            end else if (cnt_a > 0) begin
                cnt_a <= cnt_a - 1;
            end else begin
                chan_word_ack <= 1'b1;
            end
            cnt_x <= xj_pending ? cnt_x + 1 : 0;
            xj_complete <= xj_pending && cnt_x >= xj_delay;
        end
    end
endmodule
`default_nettype wire

// ==== peripheral_proc_timing_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module peripheral_proc_timing_tb_top;
    import proc_timing_pkg::*;
    localparam int M = 2;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic issue_valid = 1'b0;
    instr_t issue = '0;
    logic cp_mem_req, xj_complete, chan_word_ack, issue_ready, done;
    logic cm_busy, cm_stalled, chan_strobe, xj_pending;
    logic [15:0] elapsed;
    int num_errors = 0, checks_done = 0, strobes = 0, stalls = 0;
    int conflict_clks = 0, ack_gap = 0, xj_delay = 100;
    int n;
    peripheral_proc_timing #(.MAJOR_CLKS_P(M)) u_peripheral_proc_timing (.clk_sys(clk_sys), .srst(srst),
        .issue_valid(issue_valid), .issue(issue), .cp_mem_req(cp_mem_req), .xj_complete(xj_complete),
        .chan_word_ack(chan_word_ack), .issue_ready(issue_ready), .done(done), .elapsed(elapsed),
        .cm_busy(cm_busy), .cm_stalled(cm_stalled), .chan_strobe(chan_strobe), .xj_pending(xj_pending));
    proc_far_side u_proc_far_side (.clk_sys(clk_sys), .srst(srst), .cm_busy(cm_busy),
        .chan_strobe(chan_strobe), .xj_pending(xj_pending), .conflict_clks(conflict_clks),
        .ack_gap(ack_gap), .xj_delay(xj_delay), .cp_mem_req(cp_mem_req), .xj_complete(xj_complete),
        .chan_word_ack(chan_word_ack));
    always #2 clk_sys = ~clk_sys;
    // Pulses are tallied at the edge after they show.
    always @(posedge clk_sys) begin
        if (chan_strobe === 1'b1) strobes++;
        if (cm_stalled === 1'b1) stalls++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Offer until taken, then count clocks from the taking edge to done.
    task automatic run_op(input logic [5:0] op, input logic idx, input logic [11:0] wc);
        int k;
        k = 0;
        @(posedge clk_sys) begin
            issue_valid <= 1'b1;
            issue <= '{opcode: op, index_ref: idx, word_count: wc};
        end
        do begin
            @(posedge clk_sys);
            #1;
            k++;
        end while (issue_ready === 1'b1 && k < 1000);
        @(posedge clk_sys) issue_valid <= 1'b0;
        #1;
        // One clock has passed since the taking edge.
        n = 1;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check({k < 1000, n < 4000}, 2'b11);
    endtask
    task automatic time_op(input logic [5:0] op, input logic idx, input logic [11:0] wc, input int exp);
        run_op(op, idx, wc);
        check(n, exp * M);
        check(elapsed, exp);
    endtask
    task automatic test_table;
        time_op(6'h00, 1'b0, 12'h000, 1);
        time_op(6'h14, 1'b0, 12'h000, 1);
        time_op(6'h17, 1'b0, 12'h000, 1);
        time_op(6'h10, 1'b0, 12'h000, 2);
        time_op(6'h18, 1'b0, 12'h000, 2);
        time_op(6'h1D, 1'b0, 12'h000, 3);
        time_op(6'h20, 1'b0, 12'h000, 3);
        time_op(6'h27, 1'b0, 12'h000, 4);
        time_op(6'h28, 1'b0, 12'h000, 3);
        time_op(6'h2C, 1'b1, 12'h000, 4);
        time_op(6'h2F, 1'b1, 12'h000, 5);
        time_op(6'h01, 1'b1, 12'h000, 3);
        time_op(6'h02, 1'b0, 12'h000, 3);
        time_op(6'h37, 1'b0, 12'h000, 2);
        time_op(6'h38, 1'b0, 12'h000, 2);
        time_op(6'h3F, 1'b0, 12'h000, 2);
        $display("test_table done");
    endtask
    task automatic test_central;
        time_op(6'h30, 1'b0, 12'h000, 6);
        time_op(6'h31, 1'b0, 12'h002, 15);
        time_op(6'h33, 1'b0, 12'h000, 5);
        conflict_clks = 5;
        stalls = 0;
        run_op(6'h32, 1'b0, 12'h000);
        @(posedge clk_sys);
        #1;
        // With M = 2 the synced request covers the ticks of major cycles 3 and 4.
        check(stalls, 2);
        check(elapsed, 6 + 2);
        check(n, (6 + 2) * M);
        conflict_clks = 0;
        $display("test_central done");
    endtask
    task automatic test_channel;
        strobes = 0;
        time_op(6'h39, 1'b0, 12'h003, 7);
        @(posedge clk_sys);
        #1;
        check(strobes, 3);
        time_op(6'h39, 1'b0, 12'h000, 4);
        ack_gap = 9;
        strobes = 0;
        run_op(6'h3B, 1'b0, 12'h003);
        @(posedge clk_sys);
        #1;
        check(strobes, 3);
        check(elapsed > 7, 1);
        ack_gap = 0;
        $display("test_channel done");
    endtask
    task automatic test_exchange;
        time_op(6'h16, 1'b0, 12'h000, 20);
        check(xj_pending, 1'b1);
        @(posedge clk_sys) begin
            issue_valid <= 1'b1;
            issue <= '{opcode: 6'h18, index_ref: 1'b0, word_count: 12'h000};
        end
        repeat (10) begin
            @(posedge clk_sys);
            #1;
            check({issue_ready, done}, 2'b10);
        end
        time_op(6'h18, 1'b0, 12'h000, 2);
        $display("test_exchange done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        test_table;
        test_central;
        test_channel;
        test_exchange;
        report_and_stop;
    end
    // The tests need about 400 clocks; this limit leaves wide margin.
    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end
endmodule
bind peripheral_proc_timing proc_timing_checker #(.MAJOR_CLKS_P(MAJOR_CLKS_P)) u_proc_timing_checker (
    .clk_sys(clk_sys), .srst(srst), .issue_valid(issue_valid), .cp_mem_req(cp_mem_req),
    .xj_complete(xj_complete), .chan_word_ack(chan_word_ack), .issue_ready(issue_ready), .done(done),
    .elapsed(elapsed), .cm_busy(cm_busy), .cm_stalled(cm_stalled), .chan_strobe(chan_strobe),
    .xj_pending(xj_pending));
`default_nettype wire
